// ==== hw/typeb_pkg.sv ====
package typeb_pkg;

   // Attribute reply: buffer size multiplier and card identifier support.
   localparam logic [3:0] ATTRIB_MBLI = 4'h1;
   localparam logic [3:0] ATTRIB_CID = 4'h0;
   localparam logic [7:0] ATTRIB_REPLY = {ATTRIB_MBLI, ATTRIB_CID};

   // Halt command and its reply.
   localparam logic [7:0] HALT_CODE = 8'h50;
   localparam logic [7:0] HALT_REPLY = 8'h00;
   localparam logic [7:0] HALT_LEN = 8'h05;

   // Command header fields.
   localparam logic [7:0] CLA_ISO = 8'h00;
   localparam logic [7:0] INS_SELECT = 8'ha4;
   localparam logic [7:0] INS_READ = 8'hb0;
   localparam logic [7:0] P1_BY_FID = 8'h00;
   localparam logic [7:0] P1_EF = 8'h02;
   localparam logic [7:0] P1_BY_NAME = 8'h04;
   localparam logic [7:0] P2_FIRST = 8'h00;
   localparam logic [7:0] P2_NO_FCI = 8'h0c;
   localparam logic [7:0] LC_APP = 8'h07;
   localparam logic [7:0] LC_FID = 8'h02;
   localparam logic [7:0] LE_APP = 8'h00;
   localparam logic [8:0] HDR_LEN = 9'h005;

   // Field positions in the captured command.
   localparam logic [7:0] IDX_CLA = 8'h00;
   localparam logic [7:0] IDX_INS = 8'h01;
   localparam logic [7:0] IDX_P1 = 8'h02;
   localparam logic [7:0] IDX_P2 = 8'h03;
   localparam logic [7:0] IDX_LC = 8'h04;
   localparam logic [7:0] COUNT_MAX = 8'hff;

   // Select data values.
   localparam logic [55:0] APP_NAME = 56'hd2760000850101;
   localparam logic [15:0] FID_CC = 16'he103;
   localparam logic [15:0] FID_NDEF = 16'h0103;

   // Status words.
   localparam logic [15:0] SW_OK = 16'h9000;
   localparam logic [15:0] SW_BAD_LEN = 16'h6700;
   localparam logic [15:0] SW_BAD_P1P2 = 16'h6a86;
   localparam logic [15:0] SW_NOT_FOUND = 16'h6a82;
   localparam logic [15:0] SW_BAD_CLA = 16'h6e00;

   // CRC_B, reflected form.
   localparam logic [15:0] CRC_INIT = 16'hffff;
   localparam logic [15:0] CRC_POLY = 16'h8408;

   // Reply byte counts.
   localparam logic [1:0] NB_ONE = 2'h1;
   localparam logic [1:0] NB_TWO = 2'h2;

   typedef enum logic [2:0] {
      FILE_NONE,
      FILE_NDEF_APP,
      FILE_CC,
      FILE_NDEF,
      FILE_EF
   } file_sel_t;

   localparam file_sel_t SEL_RESET = FILE_NONE;
   localparam logic [15:0] EF_ID_RESET = 16'h0000;

   typedef struct packed {
      logic valid;
      logic [7:0] data;
      logic apdu;
      logic last;
      logic crc_ok;
   } rx_t;

   typedef struct packed {
      logic [7:0] cla;
      logic [7:0] ins;
      logic [7:0] p1;
      logic [7:0] p2;
      logic [7:0] lc;
      logic [55:0] data;
      logic [7:0] le;
      logic [7:0] count;
   } apdu_t;

endpackage

// ==== hw/crc_b_calc.sv ====
`timescale 1ns/1ps
module crc_b_calc (
   input wire logic mclk_in,
   input wire logic sys_rst_in,
   input wire logic clear_in,
   input wire logic en_in,
   input wire logic [7:0] byte_in,
   output logic [15:0] crc_out
);
   import typeb_pkg::*;

   logic [15:0] crc_q;
   logic [15:0] crc_d;

   always_comb begin
      crc_d = crc_q;
      if (clear_in) begin
         crc_d = CRC_INIT;
      end else if (en_in) begin
         crc_d = crc_q ^ {8'h00, byte_in};
         for (int i = 0; i < 8; i++) begin
            if (crc_d[0]) begin
               crc_d = (crc_d >> 1) ^ CRC_POLY;
            end else begin
               crc_d = crc_d >> 1;
            end
         end
      end
   end

   always_ff @(posedge mclk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         crc_q <= CRC_INIT;
      end else begin
         crc_q <= crc_d;
      end
   end

   // The sent value is the complement of the running register.
   assign crc_out = ~crc_q;
endmodule

// ==== hw/apdu_capture.sv ====
`timescale 1ns/1ps
module apdu_capture (
   input wire logic mclk_in,
   input wire logic sys_rst_in,
   input wire logic valid_in,
   input wire logic last_in,
   input wire logic [7:0] byte_in,
   output typeb_pkg::apdu_t apdu_out
);
   import typeb_pkg::*;

   apdu_t a_q;
   apdu_t a_d;
   logic first_q;
   logic first_d;
   logic [7:0] idx;
   logic [8:0] body_end;

   always_comb begin
      a_d = a_q;
      first_d = first_q;
      idx = first_q ? 8'h00 : a_q.count;
      body_end = HDR_LEN + {1'b0, a_q.lc};
      if (valid_in) begin
         first_d = last_in;
         if (first_q) begin
            a_d = '0;
         end
         if (idx != COUNT_MAX) begin
            a_d.count = idx + 8'h01;
         end
         case (idx)
            IDX_CLA: a_d.cla = byte_in;
            IDX_INS: a_d.ins = byte_in;
            IDX_P1: a_d.p1 = byte_in;
            IDX_P2: a_d.p2 = byte_in;
            IDX_LC: a_d.lc = byte_in;
            default: begin
               // Only the last seven body bytes are kept.
               if ({1'b0, idx} < body_end) begin
                  a_d.data = {a_q.data[47:0], byte_in};
               end else if ({1'b0, idx} == body_end) begin
                  a_d.le = byte_in;
               end
            end
         endcase
      end
   end

   always_ff @(posedge mclk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         a_q <= '0;
         first_q <= 1'b1;
      end else begin
         a_q <= a_d;
         first_q <= first_d;
      end
   end

   assign apdu_out = a_q;
endmodule

// ==== hw/typeb_halt_select_decoder.sv ====
// Function
// R1: Attribute reply is 0x10 plus CRC_B.
// R2: Valid halt command enters the halt state.
// R3: Reader puts card identifier inside halt command.
// R4: Select needs class 0x00 and instruction 0xA4.
// R5: P1 picks identifier, elementary file, or name.
// R6: Only three P1,P2 pairs accepted; others error.
// R7: P2 0x0C returns no file control information.
// R8: Lc is 7 for application, else 2.
// R9: Application name must match exactly.
// R10: Identifier 0xE103 selects capability container.
// R11: Identifier 0x0103 selects the fixed NDEF file.
// R12: Elementary file selection accepts any identifier.
// R13: Reader avoids reserved identifiers for ordinary files.
// R14: Le 0x00 only for application selection.
// R15: Tunnel mode reads come from the host.
// R16: Halt answered 0x00 plus CRC_B; others ignored.
// R17: Select reply holds only the status word.
`timescale 1ns/1ps
module typeb_halt_select_decoder (
   input wire logic mclk_in,
   input wire logic sys_rst_in,
   input typeb_pkg::rx_t rx_in,
   input wire logic attrib_ok_in,
   input wire logic wakeup_in,
   input wire logic [31:0] pupi_in,
   input wire logic tunnel_mode_in,
   input wire logic tx_ready_in,
   output logic tx_valid_out,
   output logic [7:0] tx_data_out,
   output logic tx_last_out,
   output logic halted_out,
   output typeb_pkg::file_sel_t sel_file_out,
   output logic [15:0] ef_id_out,
   output logic rd_host_req_out,
   output logic rd_mem_req_out
);
   import typeb_pkg::*;

   typedef enum logic [1:0] {
      TX_IDLE,
      TX_DATA,
      TX_CRC_LO,
      TX_CRC_HI
   } tx_state_t;

   apdu_t cmd;
   logic [15:0] crc_val;
   logic crc_clear;
   logic crc_en;

   // Frame end is seen in the same cycle as its captured last byte.
   logic done_q;
   logic done_d;
   logic apdu_q;
   logic apdu_d;

   // Reply sequencer.
   tx_state_t state_q;
   tx_state_t state_d;
   logic [15:0] buf_q;
   logic [15:0] buf_d;
   logic [1:0] left_q;
   logic [1:0] left_d;
   logic with_crc_q;
   logic with_crc_d;

   // Device state seen by the rest of the interpreter.
   logic halted_q;
   logic halted_d;
   file_sel_t sel_q;
   file_sel_t sel_d;
   logic [15:0] ef_q;
   logic [15:0] ef_d;
   logic rd_host_q;
   logic rd_host_d;
   logic rd_mem_q;
   logic rd_mem_d;

   // Decode results.
   logic is_halt;
   logic is_select;
   logic is_read;
   logic app_sel;
   logic pair_ok;
   logic le_seen;
   logic body_ok;
   logic [8:0] body_len;
   logic [15:0] sw;
   file_sel_t sel_new;
   logic [15:0] ef_new;
   logic start_attrib;
   logic start_halt;
   logic start_select;

   apdu_capture u_capture (
      .mclk_in(mclk_in),
      .sys_rst_in(sys_rst_in),
      .valid_in(rx_in.valid),
      .last_in(rx_in.last),
      .byte_in(rx_in.data),
      .apdu_out(cmd)
   );

   crc_b_calc u_crc (
      .mclk_in(mclk_in),
      .sys_rst_in(sys_rst_in),
      .clear_in(crc_clear),
      .en_in(crc_en),
      .byte_in(buf_q[15:8]),
      .crc_out(crc_val)
   );

   always_comb begin
      done_d = rx_in.valid & rx_in.last & rx_in.crc_ok;
      apdu_d = rx_in.apdu;
   end

   always_ff @(posedge mclk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         done_q <= 1'b0;
         apdu_q <= 1'b0;
      end else begin
         done_q <= done_d;
         apdu_q <= apdu_d;
      end
   end

   // Halt carries code then the four identifier bytes, first byte on top.
   always_comb begin
      is_halt = done_q & ~apdu_q & (cmd.cla == HALT_CODE)
         & (cmd.count == HALT_LEN)
         & ({cmd.ins, cmd.p1, cmd.p2, cmd.lc} == pupi_in); // see R3 R16
      is_select = done_q & apdu_q & (cmd.ins == INS_SELECT);
      is_read = done_q & apdu_q & (cmd.ins == INS_READ)
         & (cmd.cla == CLA_ISO);
   end

   // Select checks run in a fixed order; the first failure names the error.
   always_comb begin
      app_sel = 1'b0;
      pair_ok = 1'b0;
      case (cmd.p1) // see R5
         P1_BY_FID: pair_ok = (cmd.p2 == P2_NO_FCI); // see R6
         P1_EF: pair_ok = (cmd.p2 == P2_NO_FCI); // see R6
         P1_BY_NAME: begin
            pair_ok = (cmd.p2 == P2_FIRST); // see R6
            app_sel = 1'b1;
         end
         default: pair_ok = 1'b0;
      endcase
      body_len = HDR_LEN + {1'b0, cmd.lc};
      le_seen = ({1'b0, cmd.count} == body_len + 9'h001);
      body_ok = ({1'b0, cmd.count} == body_len) | le_seen;
      sw = SW_OK;
      sel_new = sel_q;
      ef_new = ef_q;
      if (cmd.cla != CLA_ISO) begin
         sw = SW_BAD_CLA; // see R4
      end else if (!pair_ok) begin
         sw = SW_BAD_P1P2; // see R6
      end else if (cmd.lc != (app_sel ? LC_APP : LC_FID)) begin
         sw = SW_BAD_LEN; // see R8
      end else if (!body_ok) begin
         sw = SW_BAD_LEN; // see R8
      end else if (le_seen != app_sel) begin
         sw = SW_BAD_LEN; // see R14
      end else if (app_sel && cmd.le != LE_APP) begin
         sw = SW_BAD_LEN; // see R14
      end else if (app_sel) begin
         if (cmd.data != APP_NAME) begin
            sw = SW_NOT_FOUND; // see R9
         end else begin
            sel_new = FILE_NDEF_APP;
         end
      end else if (cmd.p1 == P1_EF) begin
         sel_new = FILE_EF; // see R12
         ef_new = cmd.data[15:0];
      end else if (cmd.data[15:0] == FID_CC) begin
         sel_new = FILE_CC; // see R10
      end else if (cmd.data[15:0] == FID_NDEF) begin
         sel_new = FILE_NDEF; // see R11
      end else begin
         // An ordinary file under the identifier pair.
         sel_new = FILE_EF; // see R13
         ef_new = cmd.data[15:0];
      end
   end

   // A halted card answers nothing until woken by the front end.
   always_comb begin
      start_attrib = attrib_ok_in & ~halted_q & (state_q == TX_IDLE);
      start_halt = is_halt & ~halted_q & (state_q == TX_IDLE);
      start_select = is_select & ~halted_q & (state_q == TX_IDLE);
   end

   always_comb begin
      halted_d = halted_q;
      sel_d = sel_q;
      ef_d = ef_q;
      rd_host_d = 1'b0;
      rd_mem_d = 1'b0;
      if (wakeup_in) begin
         halted_d = 1'b0;
      end
      // Entering halt wins over a wake-up in the same cycle.
      if (start_halt) begin
         halted_d = 1'b1; // see R2
      end
      if (start_select) begin
         sel_d = sel_new;
         ef_d = ef_new;
      end
      if (is_read && !halted_q) begin
         rd_host_d = tunnel_mode_in; // see R15
         rd_mem_d = ~tunnel_mode_in; // see R15
      end
   end

   always_ff @(posedge mclk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         halted_q <= 1'b0;
         sel_q <= SEL_RESET;
         ef_q <= EF_ID_RESET;
         rd_host_q <= 1'b0;
         rd_mem_q <= 1'b0;
      end else begin
         halted_q <= halted_d;
         sel_q <= sel_d;
         ef_q <= ef_d;
         rd_host_q <= rd_host_d;
         rd_mem_q <= rd_mem_d;
      end
   end

   // Replies leave most significant byte first; attribute and halt replies then add CRC low then high.
   always_comb begin
      state_d = state_q;
      buf_d = buf_q;
      left_d = left_q;
      with_crc_d = with_crc_q;
      crc_clear = 1'b0;
      crc_en = 1'b0;
      case (state_q)
         TX_IDLE: begin
            if (start_attrib) begin
               buf_d = {ATTRIB_REPLY, 8'h00}; // see R1
               left_d = NB_ONE;
               with_crc_d = 1'b1; // see R1
               crc_clear = 1'b1;
               state_d = TX_DATA;
            end else if (start_halt) begin
               buf_d = {HALT_REPLY, 8'h00}; // see R16
               left_d = NB_ONE;
               with_crc_d = 1'b1; // see R16
               crc_clear = 1'b1;
               state_d = TX_DATA;
            end else if (start_select) begin
               // Status word only, no control information.
               buf_d = sw; // see R7 R17
               left_d = NB_TWO;
               with_crc_d = 1'b0;
               crc_clear = 1'b1;
               state_d = TX_DATA;
            end
         end
         TX_DATA: begin
            if (tx_ready_in) begin
               crc_en = 1'b1;
               buf_d = {buf_q[7:0], 8'h00};
               left_d = left_q - 2'h1;
               if (left_q == NB_ONE) begin
                  state_d = with_crc_q ? TX_CRC_LO : TX_IDLE;
               end
            end
         end
         TX_CRC_LO: begin
            if (tx_ready_in) begin
               state_d = TX_CRC_HI;
            end
         end
         TX_CRC_HI: begin
            if (tx_ready_in) begin
               state_d = TX_IDLE;
            end
         end
         default: state_d = TX_IDLE;
      endcase
   end

   always_ff @(posedge mclk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         state_q <= TX_IDLE;
         buf_q <= 16'h0000;
         left_q <= 2'h0;
         with_crc_q <= 1'b0;
      end else begin
         state_q <= state_d;
         buf_q <= buf_d;
         left_q <= left_d;
         with_crc_q <= with_crc_d;
      end
   end

   always_comb begin
      tx_valid_out = (state_q != TX_IDLE);
      case (state_q)
         TX_CRC_LO: tx_data_out = crc_val[7:0];
         TX_CRC_HI: tx_data_out = crc_val[15:8];
         default: tx_data_out = buf_q[15:8];
      endcase
      tx_last_out = (state_q == TX_CRC_HI)
         | ((state_q == TX_DATA) & (left_q == NB_ONE) & ~with_crc_q);
   end

   assign halted_out = halted_q;
   assign sel_file_out = sel_q;
   assign ef_id_out = ef_q;
   assign rd_host_req_out = rd_host_q;
   assign rd_mem_req_out = rd_mem_q;
endmodule

// ==== tb/typeb_checker.sv ====
`timescale 1ns/1ps
module typeb_checker
   import typeb_pkg::*;
(
   input wire logic mclk_in,
   input wire logic sys_rst_in,
   input typeb_pkg::rx_t rx_in,
   input wire logic attrib_ok_in,
   input wire logic wakeup_in,
   input wire logic [31:0] pupi_in,
   input wire logic tunnel_mode_in,
   input wire logic tx_ready_in,
   input wire logic tx_valid_out,
   input wire logic [7:0] tx_data_out,
   input wire logic tx_last_out,
   input wire logic halted_out,
   input typeb_pkg::file_sel_t sel_file_out,
   input wire logic rd_host_req_out,
   input wire logic rd_mem_req_out
);
   // Class and instruction are judged on the last byte of a frame.
   logic [7:0] idx_q, idx_d, cla_q, cla_d, ins_q, ins_d;
   logic fe, busy;
   assign fe = rx_in.valid && rx_in.last && rx_in.crc_ok && rx_in.apdu;
   assign busy = halted_out || tx_valid_out;
   always_comb begin
      idx_d = idx_q;
      cla_d = cla_q;
      ins_d = ins_q;
      if (rx_in.valid) begin
         idx_d = rx_in.last ? 8'h00 : idx_q + 8'h01;
         if (idx_q == 8'h00) cla_d = rx_in.data;
         if (idx_q == 8'h01) ins_d = rx_in.data;
      end
   end
   always_ff @(posedge mclk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         idx_q <= 8'h00;
         cla_q <= 8'h00;
         ins_q <= 8'h00;
      end else begin
         idx_q <= idx_d;
         cla_q <= cla_d;
         ins_q <= ins_d;
      end
   end
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (sys_rst_in);
   sequence s_byte(logic [7:0] b);
      rx_in.valid && !rx_in.last && rx_in.data == b;
   endsequence
   sequence s_halt_head;
      (!busy && idx_q == 8'h00) ##0 s_byte(HALT_CODE) ##1
      s_byte(pupi_in[31:24]) ##1 s_byte(pupi_in[23:16]) ##1
      s_byte(pupi_in[15:8]) ##1
      rx_in.valid && rx_in.last && rx_in.crc_ok && !rx_in.apdu;
   endsequence
   property p_fid(logic [15:0] fid, file_sel_t f);
      (!busy && idx_q == 8'h00) ##0 s_byte(CLA_ISO) ##1 s_byte(INS_SELECT)
      ##1 s_byte(P1_BY_FID) ##1 s_byte(P2_NO_FCI) ##1 s_byte(LC_FID) ##1
      s_byte(fid[15:8]) ##1 fe && rx_in.data == fid[7:0] |->
      ##2 tx_data_out == SW_OK[15:8] ##1 sel_file_out == f;
   endproperty
   a_attrib_reply: assert property (attrib_ok_in && !busy |=>
      tx_valid_out && tx_data_out == ATTRIB_REPLY)
      else $error("attribute reply wrong");
   a_halt_enter: assert property (s_halt_head
      ##0 rx_in.data == pupi_in[7:0] |-> ##2 halted_out &&
      tx_data_out == HALT_REPLY) else $error("halt not taken");
   a_halt_ignore: assert property (s_halt_head
      ##0 rx_in.data != pupi_in[7:0] |-> ##2 !halted_out && !tx_valid_out)
      else $error("foreign halt answered");
   a_halt_hold: assert property (halted_out && !wakeup_in |=>
      halted_out) else $error("halt state lost");
   a_reply_stand: assert property (tx_valid_out && !tx_ready_in |=>
      tx_valid_out && $stable(tx_data_out) && $stable(tx_last_out))
      else $error("reply byte moved");
   a_bad_class: assert property (fe && !busy && cla_d != CLA_ISO &&
      ins_d == INS_SELECT |-> ##2 tx_valid_out &&
      tx_data_out == SW_BAD_CLA[15:8])
      else $error("bad class not refused");
   a_cc_select: assert property (p_fid(FID_CC, FILE_CC))
      else $error("cc file not selected");
   a_ndef_select: assert property (p_fid(FID_NDEF, FILE_NDEF))
      else $error("ndef file not selected");
   a_sw_only: assert property (fe && !busy && cla_d == CLA_ISO &&
      ins_d == INS_SELECT ##2 tx_ready_in |-> tx_valid_out && !tx_last_out
      ##1 tx_valid_out && tx_last_out) else $error("select reply length");
   a_read_route: assert property (fe && !busy && cla_d == CLA_ISO &&
      ins_d == INS_READ |-> ##2 rd_host_req_out == tunnel_mode_in &&
      rd_mem_req_out == !tunnel_mode_in) else $error("read routed wrongly");
endmodule
bind typeb_halt_select_decoder typeb_checker chk (.mclk_in, .sys_rst_in,
   .rx_in, .attrib_ok_in, .wakeup_in, .pupi_in, .tunnel_mode_in, .tx_ready_in,
   .tx_valid_out, .tx_data_out, .tx_last_out, .halted_out, .sel_file_out,
   .rd_host_req_out, .rd_mem_req_out);

// ==== tb/pcd_model.sv ====
`timescale 1ns/1ps
module pcd_model
   import typeb_pkg::*;
(
   input wire logic mclk_in,
   input wire logic slow_in,
   output typeb_pkg::rx_t rx_out,
   output logic tx_ready_out
);
   logic [1:0] phase_q = 2'h0;
   initial begin
      rx_out = '0;
      tx_ready_out = 1'b1;
   end
   // A slow reader takes one reply byte in four, so replies must hold.
   always @(posedge mclk_in) begin
      phase_q <= phase_q + 2'h1;
      tx_ready_out <= !slow_in || phase_q == 2'h0;
   end
   // The data line shows the inverse once released, never a stale byte.
   task automatic send(input logic [7:0] b[$], input logic ap, input logic ok);
      for (int i = 0; i < b.size(); i++) begin
         @(posedge mclk_in);
         rx_out <= '{1'b1, b[i], ap, i == b.size() - 1, ok};
      end
      @(posedge mclk_in);
      rx_out <= '{1'b0, ~b[b.size() - 1], ap, 1'b0, 1'b0};
   endtask
endmodule

// ==== tb/typeb_halt_select_decoder_tb_top.sv ====
`timescale 1ns/1ps
module typeb_halt_select_decoder_tb_top;
   import typeb_pkg::*;
   logic mclk_in = 1'b0;
   logic sys_rst_in = 1'b1;
   logic attrib_ok_in = 1'b0;
   logic wakeup_in = 1'b0;
   logic [31:0] pupi_in = 32'h0;
   logic tunnel_mode_in = 1'b0;
   logic slow = 1'b0;
   rx_t rx_in;
   logic tx_ready_in, tx_valid_out, tx_last_out, halted_out;
   logic rd_host_req_out, rd_mem_req_out;
   logic [7:0] tx_data_out;
   logic [15:0] ef_id_out;
   file_sel_t sel_file_out;
   logic [8:0] exp_q[$];
   int n_errors = 0;
   int cmp_count = 0;
   int seed = 99674;
   int n_host = 0;
   int n_mem = 0;
   always #25 mclk_in = ~mclk_in;
   pcd_model rdr (.mclk_in(mclk_in), .slow_in(slow), .rx_out(rx_in),
      .tx_ready_out(tx_ready_in));
   typeb_halt_select_decoder uut (.mclk_in, .sys_rst_in, .rx_in,
      .attrib_ok_in, .wakeup_in, .pupi_in, .tunnel_mode_in, .tx_ready_in,
      .tx_valid_out, .tx_data_out, .tx_last_out, .halted_out, .sel_file_out,
      .ef_id_out, .rd_host_req_out, .rd_mem_req_out);
   task automatic check_val(input string what, input logic [15:0] e,
         input logic [15:0] g);
      cmp_count++;
      if (g !== e) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", what, e, g);
      end
   endtask
   always @(posedge mclk_in) begin
      n_host += (rd_host_req_out === 1'b1);
      n_mem += (rd_mem_req_out === 1'b1);
      if (tx_valid_out === 1'b1 && tx_ready_in === 1'b1) begin
         if (exp_q.size() == 0) check_val("unasked reply", 16'h0, 16'h1);
         else check_val("reply byte", 16'(exp_q.pop_front()),
            {7'h00, tx_last_out, tx_data_out});
      end
   end
   task automatic wait_idle();
      int n;
      n = 0;
      while ((exp_q.size() != 0 || tx_valid_out !== 1'b0) && n < 200) begin
         @(posedge mclk_in);
         n++;
      end
      if (n == 200) check_val("reply done", 16'h1, 16'h0);
      repeat (4) @(posedge mclk_in);
   endtask
   task automatic reply3(input logic [7:0] code);
      logic [15:0] c;
      c = 16'hffff ^ {8'h00, code};
      for (int i = 0; i < 8; i++) c = c[0] ? (c >> 1) ^ 16'h8408 : c >> 1;
      c = ~c;
      exp_q.push_back({1'b0, code});
      exp_q.push_back({1'b0, c[7:0]});
      exp_q.push_back({1'b1, c[15:8]});
   endtask
   task automatic sel_q(input logic [7:0] q[$], input logic [15:0] sw,
         input file_sel_t f);
      exp_q.push_back({1'b0, sw[15:8]});
      exp_q.push_back({1'b1, sw[7:0]});
      rdr.send(q, 1'b1, 1'b1);
      wait_idle();
      check_val("selected file", 16'(f), 16'(sel_file_out));
   endtask
   task automatic fsel(input logic [7:0] cla, p1, p2, lc,
         input logic [15:0] id, sw, input file_sel_t f);
      sel_q('{cla, 8'ha4, p1, p2, lc, id[15:8], id[7:0]}, sw, f);
   endtask
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   initial begin
      #1000000;
      n_errors++;
      finish_test();
   end
   initial begin
      logic [7:0] q[$];
      logic [15:0] id;
      repeat (16) @(posedge mclk_in);
      sys_rst_in <= 1'b0;
      pupi_in <= $random(seed);
      @(posedge mclk_in);
      reply3(ATTRIB_REPLY);
      attrib_ok_in <= 1'b1;
      @(posedge mclk_in);
      attrib_ok_in <= 1'b0;
      wait_idle();
      $display("attribute test done");
      q = '{8'h00, 8'ha4, 8'h04, 8'h00, 8'h07, 8'hd2, 8'h76, 8'h00, 8'h00,
         8'h85, 8'h01, 8'h01, 8'h00};
      sel_q(q, SW_OK, FILE_NDEF_APP);
      q[6] = 8'h77;
      sel_q(q, SW_NOT_FOUND, FILE_NDEF_APP);
      fsel(8'h00, 8'h00, 8'h0c, 8'h02, 16'he103, SW_OK, FILE_CC);
      fsel(8'h00, 8'h00, 8'h0c, 8'h02, 16'h0103, SW_OK, FILE_NDEF);
      rdr.send('{8'h00, 8'ha4, 8'h00, 8'h0c, 8'h02, 8'he1, 8'h03}, 1'b1, 1'b0);
      wait_idle();
      id = 16'($random(seed));
      fsel(8'h00, 8'h02, 8'h0c, 8'h02, id, SW_OK, FILE_EF);
      check_val("ef id", id, ef_id_out);
      id = 16'($random(seed)) | 16'h0800;
      fsel(8'h00, 8'h00, 8'h0c, 8'h02, id, SW_OK, FILE_EF);
      slow <= 1'b1;
      fsel(8'($random(seed)) | 8'h01, 8'h00, 8'h0c, 8'h02, id, SW_BAD_CLA,
         FILE_EF);
      fsel(8'h00, 8'h04, 8'h0c, 8'h02, id, SW_BAD_P1P2, FILE_EF);
      fsel(8'h00, 8'h02, 8'h00, 8'h02, id, SW_BAD_P1P2, FILE_EF);
      fsel(8'h00, 8'h01, 8'h0c, 8'h02, id, SW_BAD_P1P2, FILE_EF);
      fsel(8'h00, 8'h00, 8'h0c, 8'h03, id, SW_BAD_LEN, FILE_EF);
      fsel(8'h00, 8'h04, 8'h00, 8'h02, id, SW_BAD_LEN, FILE_EF);
      q = '{8'h00, 8'ha4, 8'h04, 8'h00, 8'h07, 8'hd2, 8'h76, 8'h00, 8'h00,
         8'h85, 8'h01, 8'h01, 8'h01};
      sel_q(q, SW_BAD_LEN, FILE_EF);
      void'(q.pop_back());
      sel_q(q, SW_BAD_LEN, FILE_EF);
      sel_q('{8'h00, 8'ha4, 8'h00, 8'h0c, 8'h02, 8'he1, 8'h03, 8'h00},
         SW_BAD_LEN, FILE_EF);
      $display("select test done");
      q = '{HALT_CODE, pupi_in[31:24], pupi_in[23:16], pupi_in[15:8],
         pupi_in[7:0] ^ 8'h01};
      rdr.send(q, 1'b0, 1'b1);
      wait_idle();
      check_val("halted", 16'h0, 16'(halted_out));
      q[4] = pupi_in[7:0];
      reply3(HALT_REPLY);
      rdr.send(q, 1'b0, 1'b1);
      wait_idle();
      check_val("halted", 16'h1, 16'(halted_out));
      attrib_ok_in <= 1'b1;
      @(posedge mclk_in);
      attrib_ok_in <= 1'b0;
      rdr.send('{8'h00, 8'ha4, 8'h00, 8'h0c, 8'h02, 8'h01, 8'h03}, 1'b1, 1'b1);
      wait_idle();
      check_val("selected file", 16'(FILE_EF), 16'(sel_file_out));
      wakeup_in <= 1'b1;
      @(posedge mclk_in);
      wakeup_in <= 1'b0;
      wait_idle();
      check_val("halted", 16'h0, 16'(halted_out));
      $display("halt test done");
      slow <= 1'b0;
      for (int t = 0; t < 2; t++) begin
         tunnel_mode_in <= t[0];
         rdr.send('{8'h00, 8'hb0, 8'h00, 8'h00, 8'h10}, 1'b1, 1'b1);
         wait_idle();
      end
      check_val("host reads", 16'h1, 16'(n_host));
      check_val("memory reads", 16'h1, 16'(n_mem));
      $display("read test done");
      finish_test();
   end
endmodule
